// ---- verilog/flpec_top.sv ----
// flpec_top: flash program/erase control with protection, apb registers
//
// Overview of operation
// - one of four array modes from control bits
// - latch page address and 128 bytes
// - program pulse lasts while program bit set
// - dummy write then word verify reads; here longword-aligned 32-bit reads, as for erase verify
// - erase pulse lasts while erase bit set
// - dummy write then longword erase verify
// - interrupts held off during program/erase
// - reset or low power clears controls
// - unlock clear blocks program/erase entry
// - clear block bit means erase-protected
// - read, exception or sleep during program/erase sets error
// - error keeps registers, aborts, reset or low power clears
// - control registers reachable only when enabled
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module flpec_top #(
    parameter int PAGE_N = flpec_pkg::PAGE_BYTES   // bytes per page
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire flpec_pkg::flpec_event_s evt,
    input  wire logic [31:0]           array_rd_data,
    input  wire logic [6:0]            page_rd_idx,
    output logic [7:0]                 page_rd_data,
    output flpec_pkg::flpec_array_s    array_ctl,
    output logic                       irq_hold
);
    localparam int IW = $clog2(PAGE_N);
    localparam logic [IW:0] FULL = (IW+1)'(PAGE_N);

    logic [7:0]  mode_a_r;        // flash_mode_control_a
    logic        err_r;           // flash_error_flag
    logic [7:0]  eblk_r;          // erase_block_select
    logic        access_r;        // control_access_bit
    logic [15:0] pg_addr_r;       // latched page start
    logic [IW:0] pg_cnt_r;        // bytes latched so far
    logic [7:0]  page_mem [PAGE_N]; // page latch
    logic [15:0] vf_addr_r;       // verify address
    logic        vf_armed_r;      // dummy write seen
    logic [31:0] prdata_r;        // read data flop
    logic [7:0]  pg_rd_r;         // page read flop
    flpec_pkg::flpec_mode_e mode; // decoded mode

    // apb strobes
    logic wr_en;
    logic rd_en;
    logic ctl_reg;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign pready = 1'b1;         // zero wait states

    // is the address one of the gated control registers
    function automatic logic is_ctl(input logic [7:0] a);
        is_ctl = (a == flpec_pkg::OFS_MODE_A) |
                 (a == flpec_pkg::OFS_MODE_B) |
                 (a == flpec_pkg::OFS_EBLK);
    endfunction : is_ctl

    // is the address mapped at all
    function automatic logic is_map(input logic [7:0] a);
        is_map = is_ctl(a) | (a == flpec_pkg::OFS_ACCESS) |
                 (a == flpec_pkg::OFS_PG_ADDR) |
                 (a == flpec_pkg::OFS_PG_DATA) |
                 (a == flpec_pkg::OFS_VF_ADDR) |
                 (a == flpec_pkg::OFS_VF_DATA) |
                 (a == flpec_pkg::OFS_STATUS);
    endfunction : is_map

    assign ctl_reg = is_ctl(paddr) & access_r;

    // unmapped addresses answer with an error, nothing else does
    assign pslverr = psel & penable & ~is_map(paddr);

    // write pulse bits only take when unlocked and no error
    logic allow_pe;
    assign allow_pe = mode_a_r[flpec_pkg::BIT_UNLOCK] & ~err_r;

    // mode decode: program beats erase beats verify modes
    always_comb begin
        if (mode_a_r[flpec_pkg::BIT_PROG] & allow_pe) begin
            mode = flpec_pkg::FLPEC_PROG;
        end else if (mode_a_r[flpec_pkg::BIT_ERASE] & allow_pe) begin
            mode = flpec_pkg::FLPEC_ERASE;
        end else if (mode_a_r[flpec_pkg::BIT_PVER]) begin
            mode = flpec_pkg::FLPEC_PVER;
        end else if (mode_a_r[flpec_pkg::BIT_EVER]) begin
            mode = flpec_pkg::FLPEC_EVER;
        end else begin
            mode = flpec_pkg::FLPEC_IDLE;
        end
    end

    logic busy;                   // program or erase in progress
    assign busy = (mode == flpec_pkg::FLPEC_PROG) |
                  (mode == flpec_pkg::FLPEC_ERASE);

    // error events only count while a pulse is active
    logic err_evt;
    assign err_evt = busy & (evt.flash_read | evt.exception |
                             evt.sleep);

    // mode control a: low power clears it like a reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_a_r <= flpec_pkg::RST_BYTE;
        end else if (evt.low_power) begin
            mode_a_r <= flpec_pkg::RST_BYTE;
        end else if (wr_en & ctl_reg &
                     (paddr == flpec_pkg::OFS_MODE_A)) begin
            mode_a_r <= pwdata[7:0] & flpec_pkg::MODE_A_MASK;
        end
    end

    // error flag: sticky, set wins, cleared by reset or low power
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_r <= 1'b0;
        end else if (err_evt) begin
            err_r <= 1'b1;
        end else if (evt.low_power) begin
            err_r <= 1'b0;
        end
    end

    // erase block select, one bit per block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eblk_r <= flpec_pkg::RST_BYTE;
        end else if (evt.low_power) begin
            eblk_r <= flpec_pkg::RST_BYTE;
        end else if (wr_en & ctl_reg &
                     (paddr == flpec_pkg::OFS_EBLK)) begin
            eblk_r <= pwdata[7:0];
        end
    end

    // control access enable, always reachable itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            access_r <= 1'b0;
        end else if (wr_en & (paddr == flpec_pkg::OFS_ACCESS)) begin
            access_r <= pwdata[flpec_pkg::BIT_ACCESS];
        end
    end

    // page address: only page-aligned starts (low byte 00 or 80) are taken
    logic pg_addr_ok;
    assign pg_addr_ok = (pwdata[7:0] == flpec_pkg::PG_LO0) |
                        (pwdata[7:0] == flpec_pkg::PG_LO1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pg_addr_r <= flpec_pkg::RST_ADDR;
        end else if (wr_en & (paddr == flpec_pkg::OFS_PG_ADDR) &
                     pg_addr_ok) begin
            pg_addr_r <= pwdata[15:0];
        end
    end

    // byte counter: new address restarts, full page stops
    logic pg_wr;
    assign pg_wr = wr_en & (paddr == flpec_pkg::OFS_PG_DATA) &
                   (pg_cnt_r != FULL) & ~busy;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pg_cnt_r <= '0;
        end else if (wr_en & (paddr == flpec_pkg::OFS_PG_ADDR) &
                     pg_addr_ok) begin
            pg_cnt_r <= '0;
        end else if (pg_wr) begin
            pg_cnt_r <= pg_cnt_r + 1'b1;
        end
    end

    // page latch array, no reset needed for data
    always_ff @(posedge pclk) begin
        if (pg_wr) begin
            page_mem[pg_cnt_r[IW-1:0]] <= pwdata[7:0];
        end
    end

    // page read port toward the array
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pg_rd_r <= flpec_pkg::RST_BYTE;
        end else begin
            pg_rd_r <= page_mem[page_rd_idx[IW-1:0]];
        end
    end
    assign page_rd_data = pg_rd_r;

    // verify dummy write: ff to a longword-aligned address arms reads
    logic vf_ok;
    assign vf_ok = (pwdata[7:0] == flpec_pkg::DUMMY) &
                   (pwdata[17:16] == flpec_pkg::VF_LO);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vf_addr_r  <= flpec_pkg::RST_ADDR;
            vf_armed_r <= 1'b0;
        end else if (wr_en & (paddr == flpec_pkg::OFS_VF_ADDR)) begin
            vf_addr_r  <= pwdata[31:16];
            vf_armed_r <= vf_ok;
        end
    end

    // read mux; gated registers read zero when disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                flpec_pkg::OFS_MODE_A:
                    prdata_r <= access_r ? {24'h0, mode_a_r} : '0;
                flpec_pkg::OFS_MODE_B:
                    prdata_r <= access_r ?
                        32'(err_r) << flpec_pkg::BIT_ERR : '0;
                flpec_pkg::OFS_EBLK:
                    prdata_r <= access_r ? {24'h0, eblk_r} : '0;
                flpec_pkg::OFS_ACCESS:
                    prdata_r <= 32'(access_r) << flpec_pkg::BIT_ACCESS;
                flpec_pkg::OFS_PG_ADDR:
                    prdata_r <= {16'h0, pg_addr_r};
                flpec_pkg::OFS_VF_ADDR:
                    prdata_r <= {16'h0, vf_addr_r};
                flpec_pkg::OFS_VF_DATA:
                    // verify data only when armed and no program/erase pulse is active
                    prdata_r <= (vf_armed_r & ~busy) ?
                                array_rd_data : '0;
                flpec_pkg::OFS_STATUS:
                    prdata_r <= {16'h0, 8'(pg_cnt_r), 5'h0,
                                 3'(mode)};
                default:
                    prdata_r <= '0;
            endcase
        end
    end
    assign prdata = prdata_r;

    // array controls: pulses follow the bits directly
    always_comb begin
        array_ctl = '0;
        array_ctl.prog_pulse   = (mode == flpec_pkg::FLPEC_PROG);
        array_ctl.erase_pulse  = (mode == flpec_pkg::FLPEC_ERASE);
        array_ctl.prog_verify  = (mode == flpec_pkg::FLPEC_PVER);
        array_ctl.erase_verify = (mode == flpec_pkg::FLPEC_EVER);
        // clear block bits leave those blocks protected
        array_ctl.block_sel    = eblk_r;
        array_ctl.page_addr    = pg_addr_r;
        array_ctl.verify_addr  = vf_addr_r;
    end

    // interrupt hold toward the interrupt controller
    assign irq_hold = busy;

    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_locked;
        !mode_a_r[flpec_pkg::BIT_UNLOCK] |->
            !array_ctl.prog_pulse && !array_ctl.erase_pulse;
    endproperty
    a_locked: assert property (p_locked)
        else $error("pulse while locked");
    property p_err_set;
        err_evt |=> err_r && !array_ctl.prog_pulse &&
                    !array_ctl.erase_pulse;
    endproperty
    a_err_set: assert property (p_err_set)
        else $error("error event not taken");
    property p_err_sticky;
        err_r && !evt.low_power |=> err_r;
    endproperty
    a_err_sticky: assert property (p_err_sticky)
        else $error("error flag dropped");
    property p_err_keep;
        err_r && !evt.low_power && !wr_en |=> $stable(mode_a_r);
    endproperty
    a_err_keep: assert property (p_err_keep)
        else $error("controls lost in error");
    property p_low_power;
        evt.low_power |=> mode_a_r == '0 && eblk_r == '0;
    endproperty
    a_low_power: assert property (p_low_power)
        else $error("low power did not clear");
    property p_gate;
        wr_en && !access_r && is_ctl(paddr) && !evt.low_power
            |=> $stable(mode_a_r) && $stable(eblk_r);
    endproperty
    a_gate: assert property (p_gate)
        else $error("gated write took effect");
    property p_one_mode;
        $onehot0({array_ctl.prog_pulse, array_ctl.erase_pulse,
                  array_ctl.prog_verify, array_ctl.erase_verify});
    endproperty
    a_one_mode: assert property (p_one_mode)
        else $error("more than one mode");
    property p_pulse;
        array_ctl.prog_pulse |->
            mode_a_r[flpec_pkg::BIT_PROG] && irq_hold;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("program pulse without bit");
    property p_erase_blk;
        array_ctl.erase_pulse |-> array_ctl.block_sel == eblk_r;
    endproperty
    a_erase_blk: assert property (p_erase_blk)
        else $error("block select mismatch");
    property p_page_cnt;
        pg_wr |=> pg_cnt_r == $past(pg_cnt_r) + 1'b1;
    endproperty
    a_page_cnt: assert property (p_page_cnt)
        else $error("page byte not counted");
    c_prog: cover property (array_ctl.prog_pulse [*3]);
    c_erase: cover property (array_ctl.erase_pulse ##1 !busy);
    c_err: cover property (err_evt ##1 err_r);
    c_full: cover property (pg_cnt_r == FULL);
endmodule : flpec_top
`default_nettype wire

// ---- verilog/flpec_pkg.sv ----
// flpec_pkg: register map, fields and carriers of the flash control block
package flpec_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_MODE_A  = 8'h00;
    localparam logic [7:0] OFS_MODE_B  = 8'h04;
    localparam logic [7:0] OFS_EBLK    = 8'h08;
    localparam logic [7:0] OFS_ACCESS  = 8'h0c;
    localparam logic [7:0] OFS_PG_ADDR = 8'h10;
    localparam logic [7:0] OFS_PG_DATA = 8'h14;
    localparam logic [7:0] OFS_VF_ADDR = 8'h18;
    localparam logic [7:0] OFS_VF_DATA = 8'h1c;
    localparam logic [7:0] OFS_STATUS  = 8'h20;
    // flash_mode_control_a fields
    localparam int BIT_PROG   = 0;
    localparam int BIT_ERASE  = 1;
    localparam int BIT_PVER   = 2;
    localparam int BIT_EVER   = 3;
    localparam int BIT_UNLOCK = 6;
    localparam logic [7:0] MODE_A_MASK = 8'h4f;
    // flash_mode_control_b and control_access_register fields
    localparam int BIT_ERR    = 7;
    localparam int BIT_ACCESS = 7;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_ADDR = 16'h0000;
    // page and verify constants
    localparam int PAGE_BYTES     = 128;
    localparam logic [7:0] PG_LO0 = 8'h00;
    localparam logic [7:0] PG_LO1 = 8'h80;
    localparam logic [7:0] DUMMY  = 8'hff;
    localparam logic [1:0] VF_LO  = 2'b00;
    // mode of the array
    typedef enum logic [2:0] {
        FLPEC_IDLE, FLPEC_PROG, FLPEC_PVER, FLPEC_ERASE, FLPEC_EVER
    } flpec_mode_e;
    // controls toward the flash array
    typedef struct packed {
        logic        prog_pulse;
        logic        erase_pulse;
        logic        prog_verify;
        logic        erase_verify;
        logic [7:0]  block_sel;
        logic [15:0] page_addr;
        logic [15:0] verify_addr;
    } flpec_array_s;
    // abort and error events from the cpu side
    typedef struct packed {
        logic flash_read;
        logic exception;
        logic sleep;
        logic low_power;
    } flpec_event_s;
endpackage : flpec_pkg

// ---- tb/flpec_array_model.sv ----
// flpec_array_model: behavioural flash array answering verify reads
`timescale 1ns/1ps
`default_nettype none
module flpec_array_model (
    input  wire logic                    pclk,
    input  wire flpec_pkg::flpec_array_s array_ctl,
    output logic [31:0]                  array_rd_data
);
    logic [31:0] churn_r = 32'h0000_0000; // junk seen outside verify

    // junk changes each cycle so a stale read cannot pass by luck
    always_ff @(posedge pclk) begin
        churn_r <= churn_r + 32'h3c6e_f372;
    end

    // verify data tied to the armed address, both verify kinds alike
    always_comb begin
        if (array_ctl.prog_verify || array_ctl.erase_verify) begin
            array_rd_data = {array_ctl.verify_addr, ~array_ctl.verify_addr};
        end else begin
            array_rd_data = churn_r; // no answer outside verify
        end
    end
endmodule : flpec_array_model
`default_nettype wire

// ---- tb/flash_program_erase_control_bench.sv ----
// flash_program_erase_control_bench: directed apb tests of the flash block
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_control_bench;
    logic                    pclk;          // 100 MHz clock
    logic                    presetn;       // async reset, active low
    logic                    psel;          // apb select
    logic                    penable;       // apb access phase
    logic                    pwrite;        // apb direction
    logic [7:0]              paddr;         // apb byte address
    logic [31:0]             pwdata;        // apb write data
    logic [31:0]             prdata;        // apb read data
    logic                    pready;        // apb ready
    logic                    pslverr;       // apb error
    flpec_pkg::flpec_event_s evt;           // cpu side events
    logic [31:0]             array_rd_data; // verify data from model
    logic [6:0]              page_rd_idx;   // page latch index
    logic [7:0]              page_rd_data;  // page latch byte
    flpec_pkg::flpec_array_s array_ctl;     // controls to the array
    logic                    irq_hold;      // interrupt hold-off
    int                      miscompares;   // mismatches
    int                      checks_done;   // comparisons made
    int                      cyc;           // cycles for the timeout
    logic [31:0]             rdata;         // last read data
    logic                    rerr;          // last pslverr
    int                      pulse_n;       // cycles with a pulse up
    // control program timing, 10 ns per cycle
    localparam int PROG_CYC      = 3000;    // 30 us early passes
    localparam int ERASE_CYC     = 1000;    // erase width, bench choice
    localparam int WDT_PROG_CYC  = 660000;  // 6.6 ms watchdog period
    localparam int WDT_ERASE_CYC = 1980000; // 19.8 ms watchdog period
    localparam int PROG_MAX      = 1000;    // program pass limit
    localparam int ERASE_MAX     = 100;     // erase pass limit

    flpec_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
        .array_rd_data(array_rd_data), .page_rd_idx(page_rd_idx),
        .page_rd_data(page_rd_data), .array_ctl(array_ctl),
        .irq_hold(irq_hold));
    flpec_array_model model_u (.pclk(pclk), .array_ctl(array_ctl),
        .array_rd_data(array_rd_data));

    // clock generator
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // hang guard, under nine thousand cycles are expected
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
    end

    // width of program and erase pulses as the array sees them
    always @(posedge pclk) begin
        if (array_ctl.prog_pulse || array_ctl.erase_pulse) begin
            pulse_n <= pulse_n + 1;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one apb transfer; an idle edge first keeps drivers single-assigned
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rdata);
    endtask : rd_chk

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1;
    endtask : do_reset

    // one-cycle event pulse; k 0 read, 1 exception, 2 sleep, 3 low power
    task automatic pulse_evt(input int k);
        @(posedge pclk);
        evt <= flpec_pkg::flpec_event_s'(4'b1000 >> k);
        @(posedge pclk);
        evt <= '0;
        #1;
    endtask : pulse_evt

    task automatic t_reset_access();
        chk("array_ctl", 0, 32'(array_ctl));
        chk("array_ctl hi", 0, 32'(array_ctl[43:32]));
        chk("irq_hold", 0, 32'(irq_hold));
        rd_chk("access", flpec_pkg::OFS_ACCESS, 0);
        apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0041);
        rd_chk("mode_a locked", flpec_pkg::OFS_MODE_A, 0);
        chk("pulse locked", 0, 32'(array_ctl.prog_pulse));
        apb(1'b1, flpec_pkg::OFS_ACCESS, 32'hffff_ffff);
        rd_chk("access rsvd", flpec_pkg::OFS_ACCESS, 32'h80);
        $display("test reset_access done");
    endtask : t_reset_access

    task automatic t_modes();
        apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0003);
        chk("no unlock", 0, 32'(array_ctl[43:40]));
        rd_chk("status idle", flpec_pkg::OFS_STATUS, 0);
        apb(1'b1, flpec_pkg::OFS_EBLK, 32'h0000_0004);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h40 | (32'h1 << i));
            chk("mode flags", 4'b1000 >> i, 32'(array_ctl[43:40]));
            chk("irq_hold", 32'(i < 2), 32'(irq_hold));
            apb(1'b0, flpec_pkg::OFS_STATUS, 0);
            chk("mode", (i == 0) ? 32'(flpec_pkg::FLPEC_PROG) :
                (i == 1) ? 32'(flpec_pkg::FLPEC_ERASE) :
                (i == 2) ? 32'(flpec_pkg::FLPEC_PVER) :
                32'(flpec_pkg::FLPEC_EVER), 32'(rdata[2:0]));
        end
        apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0042);
        chk("erase blk", 32'h4, 32'(array_ctl.block_sel));
        apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0040);
        chk("erase end", 0, 32'(array_ctl.erase_pulse));
        apb(1'b1, flpec_pkg::OFS_EBLK, 32'h0000_0000);
        chk("all protect", 0, 32'(array_ctl.block_sel));
        $display("test modes done");
    endtask : t_modes

    task automatic t_page();
        apb(1'b1, flpec_pkg::OFS_PG_ADDR, 32'h0000_1280);
        apb(1'b1, flpec_pkg::OFS_PG_ADDR, 32'h0000_1234);
        chk("page addr", 32'h1280, 32'(array_ctl.page_addr));
        for (int i = 0; i < 129; i++) begin
            apb(1'b1, flpec_pkg::OFS_PG_DATA, 32'(i ^ 8'h5a));
        end
        apb(1'b0, flpec_pkg::OFS_STATUS, 0);
        chk("page count", 32'h80, 32'(rdata[15:8]));
        for (int i = 0; i < 128; i++) begin
            @(posedge pclk);
            page_rd_idx <= 7'(i);
            @(posedge pclk);
            #1;
            chk("page byte", 32'(8'(i ^ 8'h5a)), 32'(page_rd_data));
        end
        $display("test page done");
    endtask : t_page

    task automatic t_verify();
        apb(1'b1, flpec_pkg::OFS_VF_ADDR, 32'h0204_00ff);
        chk("vf addr", 32'h0204, 32'(array_ctl.verify_addr));
        apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0044);
        rd_chk("pv data", flpec_pkg::OFS_VF_DATA, 32'h0204_fdfb);
        apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0048);
        rd_chk("ev data", flpec_pkg::OFS_VF_DATA, 32'h0204_fdfb);
        apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0040);
        $display("test verify done");
    endtask : t_verify

    // reprogram bit is 0 only for a wanted 0 that still reads 1
    function automatic logic [7:0] reprog(input logic [7:0] want,
                                          input logic [7:0] vf);
        return want | ~vf;
    endfunction : reprog

    // additional-program bit is 0 only where both read 0
    function automatic logic [7:0] addprog(input logic [7:0] re,
                                           input logic [7:0] vf);
        return re | vf;
    endfunction : addprog

    // bench as control program: erase one block, program one page
    task automatic t_sequence();
        logic       done;
        logic [7:0] nxt;
        int         n;
        apb(1'b1, flpec_pkg::OFS_EBLK, 32'h0000_0002);
        pulse_n = 0;
        apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0042);
        repeat (ERASE_CYC - 3) @(posedge pclk);
        apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0040);
        chk("erase width", ERASE_CYC, pulse_n);
        chk("erase wdt", 1, 32'(pulse_n < WDT_ERASE_CYC));
        // the model reads back erased on the first pass
        done = 1'b0;
        for (n = 0; n < ERASE_MAX && !done; n++) begin
            apb(1'b1, flpec_pkg::OFS_VF_ADDR, 32'h1300_00ff);
            apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0048);
            rd_chk("ev pass", flpec_pkg::OFS_VF_DATA, 32'h1300_ecff);
            done = 1'b1;
        end
        // page lies in the block just erased; two passes are run
        done = 1'b0;
        nxt = 8'h0f;
        for (n = 0; n < PROG_MAX && !done; n++) begin
            apb(1'b1, flpec_pkg::OFS_PG_ADDR, 32'h0000_1300);
            for (int i = 0; i < flpec_pkg::PAGE_BYTES; i++) begin
                apb(1'b1, flpec_pkg::OFS_PG_DATA,
                    (i == 0) ? 32'(nxt) : 32'h0000_00ff);
            end
            pulse_n = 0;
            apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0041);
            repeat (PROG_CYC - 3) @(posedge pclk);
            apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0040);
            chk("prog width", PROG_CYC, pulse_n);
            chk("prog wdt", 1, 32'(pulse_n < WDT_PROG_CYC));
            apb(1'b1, flpec_pkg::OFS_VF_ADDR, 32'h1300_00ff);
            apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0044);
            rd_chk("pv pass", flpec_pkg::OFS_VF_DATA, 32'h1300_ecff);
            done = (n == 1);
            nxt = reprog(nxt, rdata[31:24]);
            nxt = addprog(nxt, rdata[23:16]);
        end
        // second pass loaded byte 0 from the computed tables
        @(posedge pclk);
        page_rd_idx <= 7'h00;
        @(posedge pclk);
        #1;
        chk("next page", 32'h0000_00ef, 32'(page_rd_data));
        apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0040);
        $display("test sequence done");
    endtask : t_sequence

    task automatic t_error(input int k);
        do_reset();
        apb(1'b1, flpec_pkg::OFS_ACCESS, 32'h0000_0080);
        apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0041);
        pulse_evt(k);
        rd_chk("err flag", flpec_pkg::OFS_MODE_B, 32'h80);
        rd_chk("regs kept", flpec_pkg::OFS_MODE_A, 32'h41);
        chk("aborted", 0, 32'(array_ctl.prog_pulse));
        chk("irq free", 0, 32'(irq_hold));
        apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0044);
        chk("pv allowed", 1, 32'(array_ctl.prog_verify));
        apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0041);
        chk("no reentry", 0, 32'(array_ctl.prog_pulse));
        do_reset();
        apb(1'b1, flpec_pkg::OFS_ACCESS, 32'h0000_0080);
        rd_chk("err cleared", flpec_pkg::OFS_MODE_B, 0);
        $display("test error %0d done", k);
    endtask : t_error

    task automatic t_low_power();
        apb(1'b1, flpec_pkg::OFS_EBLK, 32'h0000_0001);
        apb(1'b1, flpec_pkg::OFS_MODE_A, 32'h0000_0042);
        chk("erase on", 1, 32'(array_ctl.erase_pulse));
        pulse_evt(3);
        chk("lp abort", 0, 32'(array_ctl));
        chk("lp abort hi", 0, 32'(array_ctl[43:32]));
        rd_chk("lp mode_a", flpec_pkg::OFS_MODE_A, 0);
        rd_chk("lp eblk", flpec_pkg::OFS_EBLK, 0);
        rd_chk("unmapped", 8'h40, 0);
        chk("slverr", 1, 32'(rerr));
        $display("test low_power done");
    endtask : t_low_power

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        evt = '0;
        page_rd_idx = '0;
        miscompares = 0;
        checks_done = 0;
        cyc = 0;
        pulse_n = 0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        t_reset_access();
        t_modes();
        t_page();
        t_verify();
        t_sequence();
        for (int k = 0; k < 3; k++) begin
            t_error(k);
        end
        t_low_power();
        conclude();
    end
endmodule : flash_program_erase_control_bench
`default_nettype wire
